// >>> src/ptpc_top.sv
// Port pin direction, pull control and driver routing with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "ptpc_params.svh"

module ptpc_top
   import ptpc_pkg::*;
#(
   parameter int NUM_PINS = 4,
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Mode
   input wire logic special_mode,
   // Pins
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe,
   output logic [NUM_PINS-1:0] pull_up_en,
   output logic [NUM_PINS-1:0] pull_down_en,
   // Serial peripheral interface, index 1 is pin 3
   input wire logic spi_en,
   input wire logic [1:0] spi_oe,
   input wire logic [1:0] spi_data,
   // Async serial channel, index 1 is pin 1
   input wire logic sci_en,
   input wire logic [1:0] sci_oe,
   input wire logic [1:0] sci_data,
   // LIN physical layer: index 1 is pin 2, index 0 the drive-data pin 1
   input wire logic lin_en,
   input wire logic lin_drive_data_bit,
   input wire logic [1:0] lin_data,
   // Timer compare channels 3..0, channel n associated with pin n
   input wire logic [3:0] tim_oc_en,
   input wire logic [3:0] tim_oc_out,
   // Pulse-width channels 7..0
   input wire logic [7:0] pwm_en,
   input wire logic [7:0] pwm_out,
   // Driver modules' own port bits
   input wire logic [1:0] high_side_port_bits,
   input wire logic [1:0] low_side_port_bits,
   // Driver pin levels and second routing selections
   output logic [1:0] high_side_drive,
   output logic [1:0] low_side_drive,
   output logic pwm5_trig1_on_port_s,
   output logic pwm4_trig0_on_port_s
);

   // Logic is written for exactly four pins and a 12-bit byte address
   if (NUM_PINS != 4 || ADDR_W != 12) begin : g_bad_param
      $error("ptpc_top supports NUM_PINS=4 and ADDR_W=12 only");
   end

   // Address match against a register index
   function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
      reg_hit = (addr == {idx, 2'b00});
   endfunction

   // Routing field decode: A on 11, B on 10, timer on 01, port bit on 00
   function automatic logic route_mux(input ptpc_sel_t sel, input logic a_en, input logic a,
                                      input logic b_en, input logic b, input logic t_en,
                                      input logic t, input logic port_bit);
      unique case (sel)
         2'h3: route_mux = a_en ? a : port_bit;
         2'h2: route_mux = b_en ? b : port_bit;
         2'h1: route_mux = t_en ? t : port_bit;
         2'h0: route_mux = port_bit;
      endcase
   endfunction

   ptpc_bus_t phase_q;
   logic [3:0] sync1_q, sync2_q, sync3_q, view_q;
   logic [3:0] data_q, dir_q, pull_q, pol_q;
   logic [7:0] route0_q, route1_q;
   logic route0_done_q, route1_done_q;
   logic [3:0] oe_d, out_d;
   logic [7:0] rd_d;
   logic wr_fire, rd_take;

   // Bus strobes: read data latched on the first edge, write on the answer edge
   assign avs_waitrequest = (avs_read | avs_write) & (phase_q == PTPC_BUS_IDLE);
   assign wr_fire = avs_write & (phase_q == PTPC_BUS_DONE) & avs_byteenable[0];
   assign rd_take = avs_read & (phase_q == PTPC_BUS_IDLE);

   // One wait cycle per access keeps read data from a flop
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phase_q <= PTPC_BUS_IDLE;
      end else if (phase_q == PTPC_BUS_IDLE && (avs_read || avs_write)) begin
         phase_q <= PTPC_BUS_DONE;
      end else begin
         phase_q <= PTPC_BUS_IDLE;
      end
   end

   // Three-flop pin synchronizer; view moves only when stages two and three agree
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= `PTPC_RST_PIN;
         sync2_q <= `PTPC_RST_PIN;
         sync3_q <= `PTPC_RST_PIN;
         view_q <= `PTPC_RST_PIN;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 4; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
               view_q[i] <= sync3_q[i];
            end
         end
      end
   end

   // Pin configuration registers; overrides never touch them
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         data_q <= `PTPC_RST_PIN;
         dir_q <= `PTPC_RST_PIN;
         pull_q <= `PTPC_RST_PIN;
         pol_q <= `PTPC_RST_PIN;
      end else if (wr_fire) begin
         if (reg_hit(avs_address, `PTPC_IDX_DATA)) data_q <= avs_writedata[3:0];
         if (reg_hit(avs_address, `PTPC_IDX_DIR)) dir_q <= avs_writedata[3:0];
         if (reg_hit(avs_address, `PTPC_IDX_PULL)) pull_q <= avs_writedata[3:0];
         if (reg_hit(avs_address, `PTPC_IDX_POL)) pol_q <= avs_writedata[3:0];
      end
   end

   // Routing registers: first write in normal mode locks them, special mode never locks
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         route0_q <= `PTPC_RST_ROUTE;
         route1_q <= `PTPC_RST_ROUTE;
         route0_done_q <= 1'b0;
         route1_done_q <= 1'b0;
      end else if (wr_fire) begin
         if (reg_hit(avs_address, `PTPC_IDX_ROUTE0) && (special_mode || !route0_done_q)) begin
            route0_q <= avs_writedata[7:0];
            route0_done_q <= route0_done_q | ~special_mode;
         end
         if (reg_hit(avs_address, `PTPC_IDX_ROUTE1) && (special_mode || !route1_done_q)) begin
            route1_q <= {2'b00, avs_writedata[5:4], 4'h0};
            route1_done_q <= route1_done_q | ~special_mode;
         end
      end
   end

   // Read decode; the view register ignores writes altogether
   always_comb begin
      rd_d = 8'h00;
      for (int i = 0; i < 4; i++) begin
         if (reg_hit(avs_address, `PTPC_IDX_DATA)) begin
            rd_d[i] = dir_q[i] ? data_q[i] : view_q[i];
         end
      end
      if (reg_hit(avs_address, `PTPC_IDX_VIEW)) rd_d = {4'h0, view_q};
      if (reg_hit(avs_address, `PTPC_IDX_DIR)) rd_d = {4'h0, dir_q};
      if (reg_hit(avs_address, `PTPC_IDX_PULL)) rd_d = {4'h0, pull_q};
      if (reg_hit(avs_address, `PTPC_IDX_POL)) rd_d = {4'h0, pol_q};
      if (reg_hit(avs_address, `PTPC_IDX_ROUTE0)) rd_d = route0_q;
      if (reg_hit(avs_address, `PTPC_IDX_ROUTE1)) rd_d = route1_q;
   end

   // Read data holds until the next read; unmapped addresses read zero
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h00000000;
      end else if (rd_take) begin
         avs_readdata <= {24'h000000, rd_d};
      end
   end

   // Direction and level per pin, highest priority first
   always_comb begin
      // Pin 3: serial interface, then LIN (input), timer, plain I/O
      if (spi_en) begin
         oe_d[3] = spi_oe[1];
         out_d[3] = spi_data[1];
      end else if (lin_en) begin
         oe_d[3] = 1'b0;
         out_d[3] = 1'b0;
      end else if (tim_oc_en[3]) begin
         oe_d[3] = 1'b1;
         out_d[3] = tim_oc_out[3];
      end else begin
         oe_d[3] = dir_q[3];
         out_d[3] = data_q[3];
      end
      // Pin 2: serial interface, then LIN (output), timer, plain I/O
      if (spi_en) begin
         oe_d[2] = spi_oe[0];
         out_d[2] = spi_data[0];
      end else if (lin_en) begin
         oe_d[2] = 1'b1;
         out_d[2] = lin_data[1];
      end else if (tim_oc_en[2]) begin
         oe_d[2] = 1'b1;
         out_d[2] = tim_oc_out[2];
      end else begin
         oe_d[2] = dir_q[2];
         out_d[2] = data_q[2];
      end
      // Pin 1: async channel, then LIN drive data, timer, plain I/O
      if (sci_en) begin
         oe_d[1] = sci_oe[1];
         out_d[1] = sci_data[1];
      end else if (lin_drive_data_bit) begin
         oe_d[1] = 1'b1;
         out_d[1] = lin_data[0];
      end else if (tim_oc_en[1]) begin
         oe_d[1] = 1'b1;
         out_d[1] = tim_oc_out[1];
      end else begin
         oe_d[1] = dir_q[1];
         out_d[1] = data_q[1];
      end
      // Pin 0: async channel, timer, plain I/O
      if (sci_en) begin
         oe_d[0] = sci_oe[0];
         out_d[0] = sci_data[0];
      end else if (tim_oc_en[0]) begin
         oe_d[0] = 1'b1;
         out_d[0] = tim_oc_out[0];
      end else begin
         oe_d[0] = dir_q[0];
         out_d[0] = data_q[0];
      end
   end

   // Registered pin controls; pulls drop as soon as a pin drives
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_oe <= 4'h0;
         pin_out <= 4'h0;
         pull_up_en <= 4'h0;
         pull_down_en <= 4'h0;
      end else begin
         pin_oe <= oe_d;
         pin_out <= out_d;
         pull_up_en <= pull_q & ~oe_d & ~pol_q;
         pull_down_en <= pull_q & ~oe_d & pol_q;
      end
   end

   // Driver pin sources; an unenabled routed channel falls back to the port bit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         high_side_drive <= 2'h0;
         low_side_drive <= 2'h0;
         pwm5_trig1_on_port_s <= 1'b0;
         pwm4_trig0_on_port_s <= 1'b0;
      end else begin
         high_side_drive[1] <= route_mux(route0_q[`PTPC_HS1_LSB +: 2], pwm_en[1], pwm_out[1],
            pwm_en[4], pwm_out[4], tim_oc_en[3], tim_oc_out[3],
            high_side_port_bits[1]);
         high_side_drive[0] <= route_mux(route0_q[`PTPC_HS0_LSB +: 2], pwm_en[3], pwm_out[3],
            pwm_en[3], pwm_out[3], tim_oc_en[2], tim_oc_out[2],
            high_side_port_bits[0]);
         low_side_drive[1] <= route_mux(route0_q[`PTPC_LS1_LSB +: 2], pwm_en[7], pwm_out[7],
            pwm_en[7], pwm_out[7], tim_oc_en[1], tim_oc_out[1],
            low_side_port_bits[1]);
         low_side_drive[0] <= route_mux(route0_q[`PTPC_LS0_LSB +: 2], pwm_en[5], pwm_out[5],
            pwm_en[6], pwm_out[6], tim_oc_en[0], tim_oc_out[0],
            low_side_port_bits[0]);
         pwm5_trig1_on_port_s <= route1_q[`PTPC_R1_PWM5_BIT];
         pwm4_trig0_on_port_s <= route1_q[`PTPC_R1_PWM4_BIT];
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_view_follow: assert property ((sync2_q == sync3_q) |=> view_q == $past(sync3_q))
      else $error("input view did not follow settled pin");
   a_dir_plain: assert property ((!sci_en && !tim_oc_en[0]) |=> pin_oe[0] == $past(dir_q[0]))
      else $error("pin 0 direction not from direction bit");
   a_spi_force: assert property (spi_en |=> pin_oe[3:2] == $past(spi_oe))
      else $error("serial interface did not set pins 3-2");
   a_lin_force: assert property ((lin_en && !spi_en) |=> !pin_oe[3] && pin_oe[2])
      else $error("LIN did not force pin directions");
   a_sci_first: assert property (sci_en |=> pin_oe[1:0] == $past(sci_oe))
      else $error("async channel did not own pins 1-0");
   a_tim_out: assert property ((tim_oc_en[0] && !sci_en) |=> pin_oe[0])
      else $error("timer compare did not force output");
   a_dir_kept: assert property (!(wr_fire && reg_hit(avs_address, `PTPC_IDX_DIR))
      |=> $stable(dir_q))
      else $error("direction bits changed without a write");
   a_pull_off: assert property ((pin_oe & (pull_up_en | pull_down_en)) == 4'h0)
      else $error("pull active on an output pin");
   a_route_once: assert property ((wr_fire && route0_done_q && !special_mode
      && reg_hit(avs_address, `PTPC_IDX_ROUTE0)) |=> $stable(route0_q))
      else $error("locked routing register was written");
   a_hs1_pwm1: assert property ((route0_q[7:6] == 2'h3 && pwm_en[1])
      |=> high_side_drive[1] == $past(pwm_out[1]))
      else $error("high-side pin 1 not driven by PWM1");
   a_bus_answer: assert property (avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer took more than one wait cycle");

   // Driver routing; codes 11 and 10 share a source on two of the fields
   a_hs0_pwm3: assert property ((route0_q[5] && pwm_en[3])
      |=> high_side_drive[0] == $past(pwm_out[3]))
      else $error("high-side pin 0 not driven by PWM3");
   a_ls1_pwm7: assert property ((route0_q[3] && pwm_en[7])
      |=> low_side_drive[1] == $past(pwm_out[7]))
      else $error("low-side pin 1 not driven by PWM7");
   a_ls0_pwm6: assert property ((route0_q[1:0] == 2'h2 && pwm_en[6])
      |=> low_side_drive[0] == $past(pwm_out[6]))
      else $error("low-side pin 0 not driven by PWM6");
   a_ls0_port: assert property ((route0_q[1:0] == 2'h0)
      |=> low_side_drive[0] == $past(low_side_port_bits[0]))
      else $error("low-side pin 0 not under its port bit");
   a_hs1_fallback: assert property ((route0_q[7:6] == 2'h1 && !tim_oc_en[3])
      |=> high_side_drive[1] == $past(high_side_port_bits[1]))
      else $error("disabled timer channel still drove high-side pin 1");
   a_pull_down: assert property ((pull_q[0] && !oe_d[0] && pol_q[0])
      |=> pull_down_en[0] && !pull_up_en[0])
      else $error("pin 0 pulldown not selected");
   a_pull_up: assert property ((pull_q[1] && !oe_d[1] && !pol_q[1])
      |=> pull_up_en[1] && !pull_down_en[1])
      else $error("pin 1 pullup not enabled");

   c_spi_owns: cover property (spi_en && spi_oe == 2'h2 ##1 pin_oe[3]);
   c_route_special: cover property (wr_fire && special_mode && route0_done_q);
   c_lin_routed: cover property (lin_en && !spi_en ##1 pin_oe[2]);
   c_view_read: cover property (rd_take && reg_hit(avs_address, `PTPC_IDX_VIEW));

endmodule
`default_nettype wire

// >>> common/ptpc_params.svh
// Register indices, field positions and reset values
`ifndef PTPC_PARAMS_SVH
`define PTPC_PARAMS_SVH

// Register indices; byte address is four times the index
`define PTPC_IDX_DATA 10'h240
`define PTPC_IDX_VIEW 10'h241
`define PTPC_IDX_DIR 10'h242
`define PTPC_IDX_PULL 10'h243
`define PTPC_IDX_POL 10'h244
`define PTPC_IDX_ROUTE0 10'h246
`define PTPC_IDX_ROUTE1 10'h247

// Field positions
`define PTPC_HS1_LSB 6
`define PTPC_HS0_LSB 4
`define PTPC_LS1_LSB 2
`define PTPC_LS0_LSB 0
`define PTPC_R1_PWM5_BIT 5
`define PTPC_R1_PWM4_BIT 4

// Reset values
`define PTPC_RST_PIN 4'h0
`define PTPC_RST_ROUTE 8'h00

`endif

// >>> common/ptpc_pkg.sv
// Types shared by the port pin control block
package ptpc_pkg;
   // Routing field value
   typedef logic [1:0] ptpc_sel_t;
   // Bus answer phase
   typedef enum logic {PTPC_BUS_IDLE, PTPC_BUS_DONE} ptpc_bus_t;
endpackage

// >>> test/ptpc_pin_world.sv
// Behavioural model of the board around the four port pins
`timescale 1ns/1ps
`default_nettype none
module ptpc_pin_world (
   // Clock
   input wire logic clk_sys,
   // Block pin side
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] pull_up_en,
   input wire logic [3:0] pull_down_en,
   // Board stimulus
   input wire logic [3:0] ext_en,
   input wire logic [3:0] ext_val,
   input wire logic [3:0] short_low,
   output logic [3:0] pin_in
);
   logic [3:0] float_q = 4'h0;
   // Undriven pins wander, so a stale level never passes for a real one
   always @(posedge clk_sys) begin
      float_q <= ~float_q;
   end
   // Short beats block drive, then board drive, then the pull devices
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (short_low[i]) pin_in[i] = 1'b0;
         else if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pull_down_en[i]) pin_in[i] = 1'b0;
         else if (pull_up_en[i]) pin_in[i] = 1'b1;
         else pin_in[i] = float_q[i];
      end
   end
endmodule
`default_nettype wire

// >>> test/tb_port_t_pin_control_and_routing.sv
// Self-checking bench for the port pin control and driver routing block
`timescale 1ns/1ps
`default_nettype none
`include "ptpc_params.svh"
module tb_port_t_pin_control_and_routing;
   localparam logic [11:0] A_DATA = {`PTPC_IDX_DATA, 2'b00};
   localparam logic [11:0] A_VIEW = {`PTPC_IDX_VIEW, 2'b00};
   localparam logic [11:0] A_DIR = {`PTPC_IDX_DIR, 2'b00};
   localparam logic [11:0] A_PULL = {`PTPC_IDX_PULL, 2'b00};
   localparam logic [11:0] A_POL = {`PTPC_IDX_POL, 2'b00};
   localparam logic [11:0] A_R0 = {`PTPC_IDX_ROUTE0, 2'b00};
   localparam logic [11:0] A_R1 = {`PTPC_IDX_ROUTE1, 2'b00};
   localparam logic [11:0] A_HOLE = 12'h914; // No register behind this word
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, pwm5_trig1_on_port_s, pwm4_trig0_on_port_s;
   logic special_mode = 1'b0;
   logic [3:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, e_pin;
   logic spi_en = 1'b0, sci_en = 1'b0, lin_en = 1'b0, lin_drive_data_bit = 1'b0;
   logic [1:0] spi_oe = 2'h0, spi_data = 2'h0, sci_oe = 2'h0, sci_data = 2'h0;
   logic [1:0] lin_data = 2'h0, hs_bits = 2'h0, ls_bits = 2'h0, high_side_drive, low_side_drive;
   logic [3:0] tim_oc_en = 4'h0, tim_oc_out = 4'h0, ext_en = 4'hF, ext_val = 4'h5;
   logic [3:0] short_low = 4'h0;
   logic [7:0] pwm_en = 8'h00, pwm_out = 8'h00;
   logic [11:0] regs [5] = '{A_DIR, A_PULL, A_POL, A_R0, A_R1};
   int n_errors = 0, comparisons = 0, m_data, m_dir, m_pe, m_pol, m_r0, m_r1;
   bit lk0, lk1;

   ptpc_top dut (
      .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .special_mode(special_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .spi_en(spi_en),
      .spi_oe(spi_oe), .spi_data(spi_data), .sci_en(sci_en), .sci_oe(sci_oe),
      .sci_data(sci_data), .lin_en(lin_en), .lin_drive_data_bit(lin_drive_data_bit),
      .lin_data(lin_data), .tim_oc_en(tim_oc_en), .tim_oc_out(tim_oc_out),
      .pwm_en(pwm_en), .pwm_out(pwm_out), .high_side_port_bits(hs_bits),
      .low_side_port_bits(ls_bits), .high_side_drive(high_side_drive),
      .low_side_drive(low_side_drive), .pwm5_trig1_on_port_s(pwm5_trig1_on_port_s),
      .pwm4_trig0_on_port_s(pwm4_trig0_on_port_s));
   ptpc_pin_world board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
      .ext_val(ext_val), .short_low(short_low), .pin_in(pin_in));

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Shared comparison core used by both checkers
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // One Avalon transfer; request held until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h000000, d};
      // Answer and read data are both taken at the rising edge that sees waitrequest low
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (avs_waitrequest !== 1'b0) begin
         cmp(32'h1, 32'h0, "bus timeout");
         tally_and_finish();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Write and mirror it in the model; routing locks after a normal-mode write
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      case (a)
         A_DATA: m_data = d & 15;
         A_DIR: m_dir = d & 15;
         A_PULL: m_pe = d & 15;
         A_POL: m_pol = d & 15;
         A_R0: if (special_mode || !lk0) begin
            m_r0 = d;
            lk0 = lk0 | !special_mode;
         end
         A_R1: if (special_mode || !lk1) begin
            m_r1 = d & 8'h30;
            lk1 = lk1 | !special_mode;
         end
         default: ;
      endcase
   endtask
   task automatic chk_read(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      cmp(q, exp, "register read");
   endtask
   // Driver pin source for one routing field code
   function automatic logic rt(input int s, input int p11, input int p10, input int t,
      input logic pb);
      case (s)
         3: return pwm_en[p11] ? pwm_out[p11] : pb;
         2: return pwm_en[p10] ? pwm_out[p10] : pb;
         1: return tim_oc_en[t] ? tim_oc_out[t] : pb;
         default: return pb;
      endcase
   endfunction
   // Owners applied lowest first, so a later claim wins
   task automatic chk_outs();
      logic [3:0] oe, po;
      logic [1:0] hs, ls;
      for (int i = 0; i < 4; i++) begin
         {oe[i], po[i]} = {m_dir[i], m_data[i]};
         if (tim_oc_en[i]) {oe[i], po[i]} = {1'b1, tim_oc_out[i]};
         if (i == 1 && lin_drive_data_bit) {oe[i], po[i]} = {1'b1, lin_data[0]};
         if (i >= 2 && lin_en) {oe[i], po[i]} = {i == 2, lin_data[1]};
         if (i >= 2 && spi_en) {oe[i], po[i]} = {spi_oe[i-2], spi_data[i-2]};
         if (i < 2 && sci_en) {oe[i], po[i]} = {sci_oe[i], sci_data[i]};
      end
      e_pin = (oe & po | ~oe & ext_en & ext_val | ~oe & ~ext_en & m_pe & ~m_pol) & ~short_low;
      hs = {rt(m_r0[7:6], 1, 4, 3, hs_bits[1]), rt(m_r0[5:4], 3, 3, 2, hs_bits[0])};
      ls = {rt(m_r0[3:2], 7, 7, 1, ls_bits[1]), rt(m_r0[1:0], 5, 6, 0, ls_bits[0])};
      cmp(pin_oe, oe, "pin direction");
      cmp(pin_out & oe, po & oe, "pin level");
      cmp(pull_up_en, m_pe & ~oe & ~m_pol, "pullup");
      cmp(pull_down_en, m_pe & ~oe & m_pol, "pulldown");
      cmp(high_side_drive, hs, "high side drive");
      cmp(low_side_drive, ls, "low side drive");
      cmp({pwm5_trig1_on_port_s, pwm4_trig0_on_port_s}, m_r1[5:4], "port s");
   endtask
   // Random peripheral, timer, pulse-width and board levels
   task automatic shake();
      @(posedge clk_sys);
      spi_en <= ($urandom % 3) == 0;
      sci_en <= ($urandom % 3) == 0;
      {lin_en, lin_drive_data_bit, spi_oe, spi_data, sci_oe, sci_data} <= 10'($urandom);
      {lin_data, tim_oc_en, tim_oc_out, pwm_en, pwm_out} <= 26'($urandom);
      {hs_bits, ls_bits, ext_val} <= 8'($urandom);
   endtask

   // Hang guard
   initial begin
      repeat (90000) @(posedge clk_sys);
      cmp(32'h1, 32'h0, "watchdog");
      tally_and_finish();
   end

   initial begin
      void'($urandom(32'hA0092A3B));
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      foreach (regs[i]) chk_read(regs[i], 0);
      chk_outs();
      wr(A_VIEW, 8'h0A);
      chk_read(A_VIEW, 5);
      chk_read(A_DATA, 5);
      wr(A_HOLE, 8'hFF);
      chk_read(A_HOLE, 0);
      $display("test reset and access done");
      repeat (40) begin
         shake();
         wr(A_DIR, 8'($urandom % 16));
         wr(A_DATA, 8'($urandom % 16));
         wr(A_PULL, 8'($urandom % 16));
         wr(A_POL, 8'($urandom % 16));
         idle(8);
         chk_outs();
         chk_read(A_DIR, m_dir);
         chk_read(A_VIEW, e_pin);
         chk_read(A_DATA, (m_dir & m_data) | (~m_dir & e_pin));
      end
      $display("test random ownership done");
      @(posedge clk_sys);
      {spi_en, sci_en, lin_en, lin_drive_data_bit, tim_oc_en, ext_en} <= 12'h000;
      wr(A_DIR, 8'h00);
      wr(A_PULL, 8'h0F);
      wr(A_POL, 8'h06);
      idle(8);
      chk_outs();
      chk_read(A_VIEW, e_pin);
      ext_en <= 4'hF;
      wr(A_DIR, 8'h01);
      wr(A_DATA, 8'h01);
      short_low <= 4'h1;
      idle(8);
      chk_outs();
      chk_read(A_VIEW, e_pin);
      chk_read(A_DATA, (m_dir & m_data) | (~m_dir & e_pin));
      short_low <= 4'h0;
      $display("test pulls and short done");
      special_mode <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         repeat (4) begin
            shake();
            wr(A_R0, 8'(s * 8'h55));
            wr(A_R1, 8'(s << 4));
            idle(3);
            chk_outs();
            chk_read(A_R0, m_r0);
            chk_read(A_R1, m_r1);
         end
      end
      special_mode <= 1'b0;
      wr(A_R0, 8'hE4);
      wr(A_R0, 8'h1B);
      wr(A_R1, 8'h20);
      wr(A_R1, 8'h10);
      idle(3);
      chk_read(A_R0, m_r0);
      chk_read(A_R1, m_r1);
      chk_outs();
      $display("test routing done");
      resetn <= 1'b0;
      idle(3);
      resetn <= 1'b1;
      {m_data, m_dir, m_pe, m_pol, m_r0, m_r1, lk0, lk1} = '0;
      foreach (regs[i]) chk_read(regs[i], 0);
      wr(A_R0, 8'h5A);
      chk_read(A_R0, m_r0);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
